// >>> pkg/pfc_pkg.sv
// constants and types for the pll frequency change control block
package pfc_pkg;

    // register byte offsets
    localparam logic [7:0] PFC_FREQ_OFS   = 8'h00;  // frequency_select_register
    localparam logic [7:0] PFC_WDCTL_OFS  = 8'h04;  // watchdog control and status
    localparam logic [7:0] PFC_STATUS_OFS = 8'h08;  // block status, sticky error bits write 1 to clear

    // frequency_select_register fields
    localparam int PFC_FREQ_RATIO_LSB = 0;  // ratio_select_bits [3:0]
    localparam int PFC_FREQ_SECOND_PLL_BIT  = 5;  // 1 = second_pll running
    localparam int PFC_FREQ_FIRST_PLL_BIT  = 6;  // 1 = first_pll running
    localparam int PFC_FREQ_PIN_OFF   = 7;  // 1 = bus_clock_pin high impedance unless first_pll runs

    // watchdog control fields
    localparam int PFC_WD_PRESCALE_LSB = 0;  // watchdog_prescale_field [2:0]
    localparam int PFC_WD_RUN_BIT      = 5;  // watchdog_run_bit
    localparam int PFC_WD_INTERVAL_BIT = 6;  // watchdog_interval_select, 1 = watchdog mode
    localparam int PFC_WD_TOVF_BIT     = 7;  // timer_overflow_flag, write 1 to clear
    localparam int PFC_WD_ROVF_BIT     = 8;  // reset_overflow_flag, write 1 to clear

    // status fields
    localparam int PFC_ST_BUSY_BIT   = 0;  // frequency change in progress
    localparam int PFC_ST_VALID_BIT  = 1;  // bus clock pin output stable
    localparam int PFC_ST_REJECT_BIT = 2;  // unsupported code written, sticky
    localparam int PFC_ST_SEQERR_BIT = 3;  // sequence precaution broken, sticky

    // values after reset
    localparam logic [7:0] PFC_FREQ_RST  = 8'h00;  // both plls off, ratio 0000
    localparam logic [8:0] PFC_WDCTL_RST = 9'h000;

    // permitted ratio codes, one bit per code value
    localparam logic [15:0] PFC_OK_BOTH_ON  = 16'h5771;  // codes 0,4,5,6,8,9,a,c,e
    localparam logic [15:0] PFC_OK_P2_ONLY  = 16'h5061;  // codes 0,5,6,c,e
    localparam logic [15:0] PFC_OK_P1_EXT   = 16'h0111;  // codes 0,4,8
    localparam logic [15:0] PFC_OK_P1_PIN   = 16'h0660;  // codes 5,6,9,a
    localparam logic [15:0] PFC_OK_BOTH_OFF = 16'hd771;  // codes 0,4,5,6,8,9,a,c,e,f

    // watchdog widths
    localparam int PFC_WD_CNT_W = 8;
    localparam int PFC_WD_DIV_W = 14;

    // sequence states, gray along idle -> settle
    typedef enum logic [1:0] {
        PFC_IDLE   = 2'b00,
        PFC_SETTLE = 2'b01
    } pfc_state_type;

    // code permitted for the strapped mode and the requested pll state
    function automatic logic pfc_code_ok(input logic [2:0] mode, input logic p1,
                                         input logic p2, input logic [3:0] code);
        logic [15:0] mask;
        mask = 16'h0000;
        case ({p1, p2})
            2'b11:   mask = (mode <= 3'd1) ? PFC_OK_BOTH_ON : 16'h0000;
            2'b01:   mask = (mode <= 3'd3) ? PFC_OK_P2_ONLY : 16'h0000;
            2'b10: begin
                if (mode <= 3'd1) begin
                    mask = PFC_OK_P1_EXT;
                end else if (mode == 3'd4 || mode == 3'd5) begin
                    mask = PFC_OK_P1_PIN;
                end
            end
            default: mask = (mode <= 3'd6) ? PFC_OK_BOTH_OFF : 16'h0000;
        endcase
        return mask[code];
    endfunction

    // prescaler tick for the selected watchdog division
    function automatic logic pfc_div_tick(input logic [2:0] sel, input logic [13:0] div);
        logic [13:0] m;
        m = 14'h0000;
        case (sel)
            3'd0:    m = 14'h0001;
            3'd1:    m = 14'h003f;
            3'd2:    m = 14'h007f;
            3'd3:    m = 14'h00ff;
            3'd4:    m = 14'h01ff;
            3'd5:    m = 14'h03ff;
            3'd6:    m = 14'h0fff;
            default: m = 14'h3fff;
        endcase
        return (div & m) == m;
    endfunction

endpackage

// >>> logic/pfc_top.sv
// pll frequency change control with watchdog and ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - writing the frequency register starts the watchdog by itself
// - bus clock pin output flagged invalid while plls settle after a change
// - broken precautions: plls stay as they were, watchdog does not run
// - modes 0-1 any pll mix, 2-3 first pll off, 4-5 pin input, 6 none
// - clocks stop, watchdog counts, overflow applies the new ratio
// - change-ending overflow sets no flag, no interrupt, no overflow pin
module pfc_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // strap and system observation
    input  wire logic [2:0]  clock_mode,
    input  wire logic        ext_bypass_read,
    input  wire logic        ext_area_write,
    input  wire logic        code_in_onchip_mem,
    input  wire logic        general_dma_busy,
    input  wire logic        ethernet_dma_engine_busy,
    // clock generator control
    output logic      [3:0]  ratio_select_bits,
    output logic             first_pll,
    output logic             second_pll,
    output logic             clocks_stopped,
    output logic             bus_clock_pin_oe,
    output logic             bus_clock_pin_valid,
    // watchdog events
    output logic             interval_interrupt,
    output logic             overflow_output_pin
);
    import pfc_pkg::*;

    logic [7:0]              freq_q;
    logic [7:0]              pend_q;
    logic [8:0]              wdctl_q;
    logic [PFC_WD_CNT_W-1:0] wdcnt_q;
    logic [PFC_WD_DIV_W-1:0] wddiv_q;
    pfc_state_type           state_q;
    logic                    armed_q;
    logic                    reject_q;
    logic                    seqerr_q;
    logic                    ap_wr_q;
    logic [7:0]              ap_ofs_q;
    logic [31:0]             hrdata_q;
    logic                    irq_q;
    logic                    ovf_pin_q;

    logic                    ap_valid;
    logic                    wr_freq;
    logic                    wr_wdctl;
    logic                    code_ok;
    logic                    seq_ok;
    logic                    start_chg;
    logic                    wd_tick;
    logic                    wd_ovf;
    logic                    norm_ovf;

    // address phase capture, zero wait state, always okay
    assign ap_valid  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ap_wr_q  <= 1'b0;
            ap_ofs_q <= 8'h00;
        end else begin
            ap_wr_q  <= ap_valid && hwrite;
            ap_ofs_q <= haddr[7:0];
        end
    end

    // data phase write strobes
    assign wr_freq  = ap_wr_q && (ap_ofs_q == PFC_FREQ_OFS);
    assign wr_wdctl = ap_wr_q && (ap_ofs_q == PFC_WDCTL_OFS);

    // read data loaded during the address phase, shown in the data phase
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            case (haddr[7:0])
                PFC_FREQ_OFS:   hrdata_q <= {24'h00_0000, freq_q};
                PFC_WDCTL_OFS:  hrdata_q <= {15'h0000, wdcnt_q, wdctl_q};
                PFC_STATUS_OFS: hrdata_q <= {28'h000_0000, seqerr_q, reject_q,
                                             bus_clock_pin_valid, clocks_stopped};
                default:        hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // precaution checks on the written value
    assign code_ok = pfc_code_ok(clock_mode, hwdata[PFC_FREQ_FIRST_PLL_BIT], hwdata[PFC_FREQ_SECOND_PLL_BIT],
                                 hwdata[3:0]);
    assign seq_ok  = armed_q && code_in_onchip_mem && !general_dma_busy && !ethernet_dma_engine_busy
                     && !wdctl_q[PFC_WD_RUN_BIT] && !wdctl_q[PFC_WD_INTERVAL_BIT];
    assign start_chg = wr_freq && (state_q == PFC_IDLE) && code_ok && seq_ok;

    // bypass read arms the sequence, an external write disarms it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
        end else if (ext_bypass_read) begin
            armed_q <= 1'b1;
        end else if (ext_area_write || wr_freq) begin
            armed_q <= 1'b0;
        end
    end

    // sequence state, clocks held while the watchdog times the settling
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= PFC_IDLE;
        end else begin
            case (state_q)
                PFC_IDLE:   if (start_chg) state_q <= PFC_SETTLE;
                PFC_SETTLE: if (wd_ovf) state_q <= PFC_IDLE;
                default:    state_q <= PFC_IDLE;
            endcase
        end
    end

    // requested plls and ratio held pending, applied at the ending overflow; pin-off bit taken at the write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            freq_q <= PFC_FREQ_RST;
            pend_q <= PFC_FREQ_RST;
        end else begin
            if (start_chg) begin
                pend_q <= {hwdata[7:5], 1'b0, hwdata[3:0]};
            end
            if (wr_freq && (state_q == PFC_IDLE) && code_ok) begin
                freq_q[PFC_FREQ_PIN_OFF] <= hwdata[PFC_FREQ_PIN_OFF];
            end
            if (state_q == PFC_SETTLE && wd_ovf) begin
                freq_q <= pend_q;
            end
        end
    end

    // sticky error flags, write 1 to clear, set wins
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reject_q <= 1'b0;
            seqerr_q <= 1'b0;
        end else begin
            if (wr_freq && (state_q == PFC_IDLE) && !code_ok) begin
                reject_q <= 1'b1;
            end else if (ap_wr_q && ap_ofs_q == PFC_STATUS_OFS && hwdata[PFC_ST_REJECT_BIT]) begin
                reject_q <= 1'b0;
            end
            if (wr_freq && (state_q == PFC_IDLE) && code_ok && !seq_ok) begin
                seqerr_q <= 1'b1;
            end else if (ap_wr_q && ap_ofs_q == PFC_STATUS_OFS && hwdata[PFC_ST_SEQERR_BIT]) begin
                seqerr_q <= 1'b0;
            end
        end
    end

    // watchdog prescaler and counter, run during a change or when enabled
    assign wd_tick  = pfc_div_tick(wdctl_q[2:0], wddiv_q);
    assign wd_ovf   = wd_tick && (wdcnt_q == {PFC_WD_CNT_W{1'b1}});
    assign norm_ovf = wd_ovf && (state_q == PFC_IDLE) && wdctl_q[PFC_WD_RUN_BIT];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wddiv_q <= '0;
            wdcnt_q <= '0;
        end else if (start_chg) begin
            wddiv_q <= '0;
            wdcnt_q <= '0;
        end else if (state_q == PFC_SETTLE || wdctl_q[PFC_WD_RUN_BIT]) begin
            wddiv_q <= wddiv_q + 1'b1;
            if (wd_tick) begin
                wdcnt_q <= wdcnt_q + 1'b1;
            end
        end
    end

    // watchdog control, flags only from overflows outside a change
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wdctl_q <= PFC_WDCTL_RST;
        end else begin
            if (wr_wdctl) begin
                wdctl_q[6:0] <= {hwdata[6:5], 2'b00, hwdata[2:0]};
            end
            if (norm_ovf) begin
                wdctl_q[PFC_WD_TOVF_BIT] <= 1'b1;
            end else if (wr_wdctl && hwdata[PFC_WD_TOVF_BIT]) begin
                wdctl_q[PFC_WD_TOVF_BIT] <= 1'b0;
            end
            if (norm_ovf && wdctl_q[PFC_WD_INTERVAL_BIT]) begin
                wdctl_q[PFC_WD_ROVF_BIT] <= 1'b1;
            end else if (wr_wdctl && hwdata[PFC_WD_ROVF_BIT]) begin
                wdctl_q[PFC_WD_ROVF_BIT] <= 1'b0;
            end
        end
    end

    // watchdog event outputs, one-cycle pulses
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q     <= 1'b0;
            ovf_pin_q <= 1'b0;
        end else begin
            irq_q     <= norm_ovf && !wdctl_q[PFC_WD_INTERVAL_BIT];
            ovf_pin_q <= norm_ovf && wdctl_q[PFC_WD_INTERVAL_BIT];
        end
    end

    // clock generator outputs
    assign ratio_select_bits   = freq_q[3:0];
    assign first_pll           = freq_q[PFC_FREQ_FIRST_PLL_BIT];
    assign second_pll          = freq_q[PFC_FREQ_SECOND_PLL_BIT];
    assign clocks_stopped      = (state_q == PFC_SETTLE);
    assign bus_clock_pin_oe    = !freq_q[PFC_FREQ_PIN_OFF] || freq_q[PFC_FREQ_FIRST_PLL_BIT];
    assign bus_clock_pin_valid = (state_q == PFC_IDLE);
    assign interval_interrupt  = irq_q;
    assign overflow_output_pin = ovf_pin_q;

endmodule

`default_nettype wire

// >>> tb/pfc_top_monitor.sv
// port-level assertion checker for the frequency change block
`timescale 1ns/10ps
`default_nettype none
module pfc_top_monitor
    import pfc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // bus address phase
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    // strap and system observation
    input wire logic [2:0]  clock_mode,
    input wire logic        code_in_onchip_mem,
    input wire logic        general_dma_busy,
    input wire logic        ethernet_dma_engine_busy,
    // clock generator control and watchdog events
    input wire logic [3:0]  ratio_select_bits,
    input wire logic        first_pll,
    input wire logic        second_pll,
    input wire logic        clocks_stopped,
    input wire logic        bus_clock_pin_oe,
    input wire logic        bus_clock_pin_valid,
    input wire logic        interval_interrupt,
    input wire logic        overflow_output_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic wr_ap_q;
    // frequency register write address phase, one cycle late
    always_ff @(posedge clk_sys) begin
        wr_ap_q <= !sys_rst && hsel && hready && htrans[1] && hwrite && (haddr[7:0] == PFC_FREQ_OFS);
    end
    // settling window and the quiet cycles after it
    sequence settle_s;
        (clocks_stopped && !bus_clock_pin_valid) [*8];
    endsequence
    sequence quiet_s;
        (!interval_interrupt && !overflow_output_pin) [*2];
    endsequence
    start_wd_a: assert property ($rose(clocks_stopped) |-> $past(wr_ap_q))
        else $error("settling began without a frequency register write");
    precaution_ok_a: assert property (
        $rose(clocks_stopped) |-> $past(code_in_onchip_mem && !general_dma_busy && !ethernet_dma_engine_busy))
        else $error("settling began with a precaution broken");
    pin_invalid_a: assert property ($rose(clocks_stopped) |-> settle_s)
        else $error("bus clock pin not flagged invalid while settling");
    pin_valid_a: assert property (!clocks_stopped |-> bus_clock_pin_valid)
        else $error("bus clock pin flagged invalid outside settling");
    apply_end_a: assert property (
        !$stable({ratio_select_bits, first_pll, second_pll}) |-> $fell(clocks_stopped))
        else $error("clock setting changed outside a settling end");
    quiet_end_a: assert property ($fell(clocks_stopped) |-> quiet_s)
        else $error("watchdog event at the end of a frequency change");
    mode_pll_a: assert property (
        (!first_pll || clock_mode inside {3'h0, 3'h1, 3'h4, 3'h5}) && (!second_pll || clock_mode <= 3'h3))
        else $error("pll state not allowed in this mode");
    pin_code_a: assert property (
        first_pll && !second_pll && clock_mode[2] |-> ratio_select_bits inside {4'h5, 4'h6, 4'h9, 4'ha})
        else $error("unsupported ratio applied for pin input");
    pin_drive_a: assert property (first_pll |-> bus_clock_pin_oe)
        else $error("bus clock pin released while first pll runs");
endmodule
bind pfc_top pfc_top_monitor mon (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .clock_mode,
    .code_in_onchip_mem, .general_dma_busy, .ethernet_dma_engine_busy, .ratio_select_bits, .first_pll,
    .second_pll, .clocks_stopped, .bus_clock_pin_oe, .bus_clock_pin_valid, .interval_interrupt,
    .overflow_output_pin);
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the frequency change block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pfc_pkg::*;
    // bench drives
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  clock_mode = 3'h0;
    logic        ext_bypass_read = 1'b0;
    logic        ext_area_write = 1'b0;
    logic        code_in_onchip_mem = 1'b1;
    logic        general_dma_busy = 1'b0;
    logic        ethernet_dma_engine_busy = 1'b0;
    // design outputs
    wire logic [31:0] hrdata;
    wire logic [3:0]  ratio_select_bits;
    wire logic        hready, hreadyout, hresp, first_pll, second_pll, clocks_stopped;
    wire logic        bus_clock_pin_oe, bus_clock_pin_valid, interval_interrupt, overflow_output_pin;
    logic [31:0] rd;
    int          n_fail = 0, checks = 0, cyc = 0, n_ovf = 0, n_iti = 0, p0, n;
    assign hready = hreadyout;
    pfc_top uut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
        .hreadyout, .hresp, .clock_mode, .ext_bypass_read, .ext_area_write, .code_in_onchip_mem,
        .general_dma_busy, .ethernet_dma_engine_busy, .ratio_select_bits, .first_pll, .second_pll,
        .clocks_stopped, .bus_clock_pin_oe, .bus_clock_pin_valid, .interval_interrupt, .overflow_output_pin);
    always #5 clk_sys = ~clk_sys;
    // cycle ceiling and watchdog pulse tally
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (overflow_output_pin === 1'b1) n_ovf <= n_ovf + 1;
        if (interval_interrupt === 1'b1) n_iti <= n_iti + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            complete_run;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer, read data left in rd
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(a, 1'b0, 32'h0);
        chk(rd & m, e);
    endtask
    // arm with a bypass read, break the chosen precautions, write the frequency register
    task automatic freq_try(input logic [2:0] m, input logic [3:0] bad, input logic [31:0] v);
        clock_mode <= m;
        ext_bypass_read <= 1'b1;
        @(posedge clk_sys);
        ext_bypass_read <= 1'b0;
        ext_area_write <= bad[0];
        general_dma_busy <= bad[1];
        ethernet_dma_engine_busy <= bad[2];
        code_in_onchip_mem <= !bad[3];
        @(posedge clk_sys);
        ext_area_write <= 1'b0;
        ahb(PFC_FREQ_OFS, 1'b1, v);
        general_dma_busy <= 1'b0;
        ethernet_dma_engine_busy <= 1'b0;
        code_in_onchip_mem <= 1'b1;
        #1;
    endtask
    task automatic t_reset;
        rdchk(PFC_FREQ_OFS, 32'hff, 32'h0);
        rdchk(PFC_WDCTL_OFS, 32'h1ff, 32'h0);
        rdchk(PFC_STATUS_OFS, 32'hf, 32'h2);
        rdchk(8'h0c, 32'hffffffff, 32'h0);
        chk({hresp, hreadyout}, 2'h1);
        $display("test reset done");
    endtask
    // each broken arming, dma or code-location precaution leaves plls and watchdog alone
    task automatic t_seqerr;
        for (int b = 0; b < 4; b++) begin
            freq_try(3'h0, 4'h1 << b, 32'h68);
            chk(clocks_stopped, 1'b0);
            chk({first_pll, second_pll, ratio_select_bits}, 6'h0);
            rdchk(PFC_STATUS_OFS, 32'hf, 32'ha);
            ahb(PFC_STATUS_OFS, 1'b1, 32'h8);
        end
        $display("test seqerr done");
    endtask
    // codes outside the mode's set are refused
    task automatic t_reject;
        for (int i = 0; i < 2; i++) begin
            freq_try(i ? 3'h0 : 3'h2, 4'h0, i ? 32'h6f : 32'h48);
            chk({clocks_stopped, first_pll, second_pll}, 3'h0);
            rdchk(PFC_STATUS_OFS, 32'hf, 32'h6);
            ahb(PFC_STATUS_OFS, 1'b1, 32'h4);
        end
        $display("test reject done");
    endtask
    // good change: clocks stop, watchdog runs, new ratio applied quietly
    task automatic t_change;
        for (int i = 0; i < 2; i++) begin
            ahb(PFC_WDCTL_OFS, 1'b1, 32'h0);
            p0 = n_ovf + n_iti;
            freq_try(i ? 3'h0 : 3'h4, 4'h0, i ? 32'h68 : 32'h45);
            chk(clocks_stopped, 1'b1);
            chk(bus_clock_pin_valid, 1'b0);
            ahb(PFC_FREQ_OFS, 1'b1, 32'h0);
            n = 3;
            while (clocks_stopped === 1'b1 && n < 2000) begin
                @(posedge clk_sys);
                #1;
                n = n + 1;
            end
            chk(n >= 505 && n <= 520, 1'b1);
            repeat (2) @(posedge clk_sys);
            chk({first_pll, second_pll, ratio_select_bits}, i ? 6'h38 : 6'h25);
            chk({bus_clock_pin_valid, bus_clock_pin_oe}, 2'h3);
            chk(n_ovf + n_iti - p0, 32'h0);
            rdchk(PFC_WDCTL_OFS, 32'h180, 32'h0);
            rdchk(PFC_FREQ_OFS, 32'hff, i ? 32'h68 : 32'h45);
            rdchk(PFC_STATUS_OFS, 32'hf, 32'h2);
        end
        $display("test change done");
    endtask
    // pin-off request while the first pll runs keeps the pin driven
    task automatic t_pin;
        ahb(PFC_FREQ_OFS, 1'b1, 32'he8);
        #1;
        chk(bus_clock_pin_oe, 1'b1);
        chk({first_pll, second_pll, ratio_select_bits}, 6'h38);
        rdchk(PFC_FREQ_OFS, 32'hff, 32'he8);
        rdchk(PFC_STATUS_OFS, 32'hf, 32'ha);
        ahb(PFC_STATUS_OFS, 1'b1, 32'h8);
        $display("test pin done");
    endtask
    // plain watchdog overflow in both modes, for contrast with the quiet change
    task automatic t_watchdog;
        for (int s = 1; s >= 0; s--) begin
            p0 = n_ovf;
            n = n_iti;
            ahb(PFC_WDCTL_OFS, 1'b1, 32'h20 | (s << 6));
            for (int i = 0; i < 2000 && n_ovf + n_iti == p0 + n; i++) @(posedge clk_sys);
            chk(n_ovf - p0, s);
            chk(n_iti - n, 1 - s);
            rdchk(PFC_WDCTL_OFS, 32'h1e0, 32'ha0 | (s << 6) | (s << 8));
            ahb(PFC_WDCTL_OFS, 1'b1, 32'h180);
        end
        $display("test watchdog done");
    endtask
    task automatic complete_run;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_seqerr;
        t_reject;
        t_change;
        t_pin;
        t_watchdog;
        complete_run;
    end
endmodule
`default_nettype wire
